/* mpc_pkg.sv */
// Function
// - Bidir function resets 0010b; 0,1,2,4 meanings
// - Bidir code 7 powers down ADC channels
// - Bidir code 8 switches microphone bias supply
// - Code 9 general input, 10 master clock
// - Code 11 feeds audio serial port data
// - Codes 12, 13 pulse-density data inputs
// - Bidir drive resets 010b; six drive modes
// - Bit 3 of configs reserved, reads zero
// - Output pin function resets 0000b; 0,1,2,4
// - Output drive resets 000b; codes 0,1,3,5
// - General output drives output-value register bit
package mpc_pkg;

  localparam int MPC_AW = 8;
  localparam int MPC_DW = 32;

  // Register indices; byte address is four times the index
  localparam logic [7:0] MPC_IDX_BCFG = 8'h21;
  localparam logic [7:0] MPC_IDX_OCFG = 8'h22;
  localparam logic [7:0] MPC_IDX_VAL  = 8'h29;
  localparam logic [7:0] MPC_IDX_MON  = 8'h2a;
  localparam logic [7:0] MPC_ADDR_BCFG = 8'(MPC_IDX_BCFG * 4);
  localparam logic [7:0] MPC_ADDR_OCFG = 8'(MPC_IDX_OCFG * 4);
  localparam logic [7:0] MPC_ADDR_VAL  = 8'(MPC_IDX_VAL * 4);
  localparam logic [7:0] MPC_ADDR_MON  = 8'(MPC_IDX_MON * 4);

  // Field positions
  localparam int MPC_FN_MSB  = 7;
  localparam int MPC_FN_LSB  = 4;
  localparam int MPC_RSV_BIT = 3;
  localparam int MPC_DRV_MSB = 2;
  localparam int MPC_BVAL_BIT = 7;
  localparam int MPC_OVAL_BIT = 6;
  localparam int MPC_MON_BIT  = 7;

  // Reset values
  localparam logic [7:0] MPC_BCFG_RST = 8'h22;
  localparam logic [7:0] MPC_OCFG_RST = 8'h00;

  // Function codes
  localparam logic [3:0] FN_OFF     = 4'h0;
  localparam logic [3:0] FN_GEN_OUT = 4'h1;
  localparam logic [3:0] FN_IRQ     = 4'h2;
  localparam logic [3:0] FN_PDMCK   = 4'h4;
  localparam logic [3:0] FN_PWRDN   = 4'h7;
  localparam logic [3:0] FN_BIAS    = 4'h8;
  localparam logic [3:0] FN_GEN_IN  = 4'h9;
  localparam logic [3:0] FN_MCLK    = 4'ha;
  localparam logic [3:0] FN_SER_IN  = 4'hb;
  localparam logic [3:0] FN_PDMA    = 4'hc;
  localparam logic [3:0] FN_PDMB    = 4'hd;

  // Drive codes
  localparam logic [2:0] DRV_HIZ  = 3'h0;
  localparam logic [2:0] DRV_PP   = 3'h1;
  localparam logic [2:0] DRV_SLWH = 3'h2;
  localparam logic [2:0] DRV_SLZH = 3'h3;
  localparam logic [2:0] DRV_WLSH = 3'h4;
  localparam logic [2:0] DRV_ZLSH = 3'h5;

  localparam logic [1:0] MPC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] MPC_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic              awvalid;
    logic [MPC_AW-1:0] awaddr;
    logic              wvalid;
    logic [MPC_DW-1:0] wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [MPC_AW-1:0] araddr;
    logic              rready;
  } mpc_axi_req_t;

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [MPC_DW-1:0] rdata;
    logic [1:0]        rresp;
  } mpc_axi_rsp_t;

  typedef struct packed {
    logic bout;
    logic boe;
    logic bweak;
    logic oout;
    logic ooe;
  } mpc_pins_t;

  typedef struct packed {
    logic pwrdn;
    logic bias;
    logic gen_in;
    logic mclk;
    logic ser_in;
    logic pdma;
    logic pdmb;
  } mpc_route_t;

  typedef struct packed {
    logic              aw_got;
    logic [MPC_AW-1:0] aw_addr;
    logic              w_got;
    logic [7:0]        w_data;
    logic              w_en;
    mpc_axi_rsp_t      rsp;
    logic [7:0]        bcfg;
    logic [7:0]        ocfg;
    logic              bval;
    logic              oval;
    logic [1:0]        bsync;
    mpc_pins_t         pins;
    mpc_route_t        route;
  } mpc_state_t;

endpackage : mpc_pkg

/* mpc_top.sv */
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
module mpc_top (
  input  wire logic                  I_REF_CLK,
  input  wire logic                  I_SRST,
  input  wire logic                  I_CE,
  input  wire mpc_pkg::mpc_axi_req_t I_AXI,
  output mpc_pkg::mpc_axi_rsp_t      O_AXI,
  input  wire logic                  I_BIDIR_IN,
  input  wire logic                  I_IRQ,
  input  wire logic                  I_PDM_CLK,
  output logic                       O_BIDIR_OUT,
  output logic                       O_BIDIR_OE,
  output logic                       O_BIDIR_WEAK,
  output logic                       O_OUT_OUT,
  output logic                       O_OUT_OE,
  output logic                       O_ADC_PWRDN,
  output logic                       O_BIAS_EN,
  output logic                       O_GEN_IN,
  output logic                       O_MCLK,
  output logic                       O_SER_IN,
  output logic                       O_PDM_DIN_A,
  output logic                       O_PDM_DIN_B
);
  import mpc_pkg::*;

  mpc_state_t q;
  mpc_state_t d;

  logic [3:0] bfn;
  logic [2:0] bdrv;
  logic [3:0] ofn;
  logic [2:0] odrv;

  assign bfn  = q.bcfg[MPC_FN_MSB:MPC_FN_LSB];
  assign bdrv = q.bcfg[MPC_DRV_MSB:0];
  assign ofn  = q.ocfg[MPC_FN_MSB:MPC_FN_LSB];
  assign odrv = q.ocfg[MPC_DRV_MSB:0];

  // Output source per function: {enable, value}
  function automatic logic [1:0] src_value(input logic [3:0] fn, input logic out_val,
                                           input logic irq, input logic pdm_clk);
    logic [1:0] r;
    r = 2'h0;
    case (fn)
      FN_GEN_OUT: r = {1'b1, out_val};
      FN_IRQ:   r = {1'b1, irq};
      FN_PDMCK: r = {1'b1, pdm_clk};
      default:  r = 2'h0;
    endcase
    return r;
  endfunction : src_value

  // Pad control per drive mode: {oe, out, weak}
  function automatic logic [2:0] drive_pin(input logic [2:0] drv, input logic v,
                                           input logic en);
    logic [2:0] r;
    r = 3'h0;
    if (en) begin
      case (drv)
        DRV_PP:   r = {1'b1, v, 1'b0};
        DRV_SLWH: r = {1'b1, v, v};
        DRV_SLZH: r = v ? 3'h0 : {1'b1, 1'b0, 1'b0};
        DRV_WLSH: r = {1'b1, v, ~v};
        DRV_ZLSH: r = v ? {1'b1, 1'b1, 1'b0} : 3'h0;
        default:  r = 3'h0;
      endcase
    end
    return r;
  endfunction : drive_pin

  function automatic logic addr_known(input logic [MPC_AW-1:0] a);
    return (a == MPC_ADDR_BCFG) || (a == MPC_ADDR_OCFG) ||
           (a == MPC_ADDR_VAL) || (a == MPC_ADDR_MON);
  endfunction : addr_known

  logic [1:0] bsrc;
  logic [1:0] osrc;
  logic [2:0] bpad;
  logic [2:0] opad;
  logic [2:0] odrv_ok;

  always_comb begin
    d = q;

    // Write address and data are taken independently
    if (I_AXI.awvalid && q.rsp.awready) begin
      d.aw_got  = 1'b1;
      d.aw_addr = I_AXI.awaddr;
    end
    if (I_AXI.wvalid && q.rsp.wready) begin
      d.w_got  = 1'b1;
      d.w_data = I_AXI.wdata[7:0];
      d.w_en   = I_AXI.wstrb[0];
    end
    if (q.rsp.bvalid && I_AXI.bready) begin
      d.rsp.bvalid = 1'b0;
    end
    if (q.aw_got && q.w_got && !q.rsp.bvalid) begin
      d.aw_got     = 1'b0;
      d.w_got      = 1'b0;
      d.rsp.bvalid = 1'b1;
      d.rsp.bresp  = addr_known(q.aw_addr) ? MPC_RESP_OKAY : MPC_RESP_SLVERR;
      if (q.w_en) begin
        case (q.aw_addr)
          MPC_ADDR_BCFG: begin
            d.bcfg              = q.w_data;
            d.bcfg[MPC_RSV_BIT] = 1'b0;
          end
          MPC_ADDR_OCFG: begin
            d.ocfg              = q.w_data;
            d.ocfg[MPC_RSV_BIT] = 1'b0;
          end
          MPC_ADDR_VAL: begin
            d.bval = q.w_data[MPC_BVAL_BIT];
            d.oval = q.w_data[MPC_OVAL_BIT];
          end
          default: begin
            d.bval = q.bval;
          end
        endcase
      end
    end
    d.rsp.awready = !d.aw_got && !d.rsp.bvalid;
    d.rsp.wready  = !d.w_got && !d.rsp.bvalid;

    // Read channel, one outstanding read
    if (q.rsp.rvalid && I_AXI.rready) begin
      d.rsp.rvalid = 1'b0;
    end
    if (I_AXI.arvalid && q.rsp.arready) begin
      d.rsp.rvalid = 1'b1;
      d.rsp.rresp  = addr_known(I_AXI.araddr) ? MPC_RESP_OKAY : MPC_RESP_SLVERR;
      case (I_AXI.araddr)
        MPC_ADDR_BCFG: d.rsp.rdata = {24'h0, q.bcfg};
        MPC_ADDR_OCFG: d.rsp.rdata = {24'h0, q.ocfg};
        MPC_ADDR_VAL:  d.rsp.rdata = {24'h0, q.bval, q.oval, 6'h0};
        MPC_ADDR_MON:  d.rsp.rdata = {24'h0, q.route.gen_in, 7'h0};
        default:       d.rsp.rdata = 32'h0;
      endcase
    end
    d.rsp.arready = !d.rsp.rvalid;

    // Pin level into the clock domain
    d.bsync = {q.bsync[0], I_BIDIR_IN};

    // Input functions of the bidirectional pin
    d.route.pwrdn = (bfn == FN_PWRDN) && q.bsync[1];
    d.route.bias  = (bfn == FN_BIAS) && q.bsync[1];
    d.route.gen_in = (bfn == FN_GEN_IN) && q.bsync[1];
    d.route.mclk  = (bfn == FN_MCLK) && q.bsync[1];
    d.route.ser_in = (bfn == FN_SER_IN) && q.bsync[1];
    d.route.pdma  = (bfn == FN_PDMA) && q.bsync[1];
    d.route.pdmb  = (bfn == FN_PDMB) && q.bsync[1];

    // Output functions; other codes leave the driver off
    bsrc = src_value(bfn, q.bval, I_IRQ, I_PDM_CLK);
    osrc = src_value(ofn, q.oval, I_IRQ, I_PDM_CLK);
    bpad = drive_pin(bdrv, bsrc[0], bsrc[1]);
    // Output pin lacks the weak drive modes
    odrv_ok = ((odrv == DRV_SLWH) || (odrv == DRV_WLSH)) ? DRV_HIZ : odrv;
    opad = drive_pin(odrv_ok, osrc[0], osrc[1]);
    d.pins.boe   = bpad[2];
    d.pins.bout  = bpad[1];
    d.pins.bweak = bpad[0];
    d.pins.ooe   = opad[2];
    d.pins.oout  = opad[1];
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      q      <= '0;
      q.bcfg <= MPC_BCFG_RST;
      q.ocfg <= MPC_OCFG_RST;
    end else if (I_CE) begin
      q <= d;
    end
  end

  assign O_AXI        = q.rsp;
  assign O_BIDIR_OUT  = q.pins.bout;
  assign O_BIDIR_OE   = q.pins.boe;
  assign O_BIDIR_WEAK = q.pins.bweak;
  assign O_OUT_OUT    = q.pins.oout;
  assign O_OUT_OE     = q.pins.ooe;
  assign O_ADC_PWRDN  = q.route.pwrdn;
  assign O_BIAS_EN    = q.route.bias;
  assign O_GEN_IN     = q.route.gen_in;
  assign O_MCLK       = q.route.mclk;
  assign O_SER_IN     = q.route.ser_in;
  assign O_PDM_DIN_A  = q.route.pdma;
  assign O_PDM_DIN_B  = q.route.pdmb;

  // Checks
  property p_bcfg_rst;
    @(posedge I_REF_CLK) $fell(I_SRST) |-> (q.bcfg == MPC_BCFG_RST) && (q.ocfg == MPC_OCFG_RST);
  endproperty
  a_bcfg_rst: assert property (p_bcfg_rst) else $error("config reset value wrong");

  property p_irq_out;
    @(posedge I_REF_CLK) disable iff (I_SRST)
      I_CE && (bfn == FN_IRQ) && (bdrv == DRV_PP) |=> O_BIDIR_OE && (O_BIDIR_OUT == $past(I_IRQ));
  endproperty
  a_irq_out: assert property (p_irq_out) else $error("interrupt not on bidir pin");

  property p_pwrdn;
    @(posedge I_REF_CLK) disable iff (I_SRST)
      I_CE && (bfn == FN_PWRDN) |=> (O_ADC_PWRDN == $past(q.bsync[1])) && !O_BIAS_EN;
  endproperty
  a_pwrdn: assert property (p_pwrdn) else $error("power-down not routed");

  property p_bias;
    @(posedge I_REF_CLK) disable iff (I_SRST)
      I_CE && (bfn == FN_BIAS) |=> (O_BIAS_EN == $past(q.bsync[1])) && !O_ADC_PWRDN;
  endproperty
  a_bias: assert property (p_bias) else $error("bias enable not routed");

  property p_gen_in;
    @(posedge I_REF_CLK) disable iff (I_SRST)
      I_CE && (bfn == FN_GEN_IN) |=> (O_GEN_IN == $past(q.bsync[1])) && !O_MCLK;
  endproperty
  a_gen_in: assert property (p_gen_in) else $error("general input not routed");

  property p_ser_in;
    @(posedge I_REF_CLK) disable iff (I_SRST)
      I_CE && (bfn == FN_SER_IN) |=> (O_SER_IN == $past(q.bsync[1])) && !O_GEN_IN;
  endproperty
  a_ser_in: assert property (p_ser_in) else $error("serial input not routed");

  property p_pdm;
    @(posedge I_REF_CLK) disable iff (I_SRST)
      I_CE && (bfn == FN_PDMB) |=> (O_PDM_DIN_B == $past(q.bsync[1])) && !O_PDM_DIN_A;
  endproperty
  a_pdm: assert property (p_pdm) else $error("pulse-density data not routed");

  property p_open_drain;
    @(posedge I_REF_CLK) disable iff (I_SRST)
      I_CE && (bfn == FN_GEN_OUT) && (bdrv == DRV_SLZH) && q.bval |=> !O_BIDIR_OE;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("released high still driven");

  property p_rsv_zero;
    @(posedge I_REF_CLK) disable iff (I_SRST)
      q.rsp.rvalid && (q.rsp.rresp == MPC_RESP_OKAY) |-> (q.rsp.rdata[MPC_RSV_BIT] == 1'b0);
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bit reads one");

  property p_out_gen;
    @(posedge I_REF_CLK) disable iff (I_SRST)
      I_CE && (ofn == FN_GEN_OUT) && (odrv == DRV_PP) |=>
        O_OUT_OE && (O_OUT_OUT == $past(q.oval));
  endproperty
  a_out_gen: assert property (p_out_gen) else $error("output pin value wrong");

  property p_out_rsv_drv;
    @(posedge I_REF_CLK) disable iff (I_SRST)
      I_CE && (odrv == DRV_WLSH) |=> !O_OUT_OE;
  endproperty
  a_out_rsv_drv: assert property (p_out_rsv_drv) else $error("reserved drive enabled");

  property p_bidir_gen;
    @(posedge I_REF_CLK) disable iff (I_SRST)
      I_CE && (bfn == FN_GEN_OUT) && (bdrv == DRV_PP) |=> O_BIDIR_OUT == $past(q.bval);
  endproperty
  a_bidir_gen: assert property (p_bidir_gen) else $error("bidir output value wrong");

  property p_input_hiz;
    @(posedge I_REF_CLK) disable iff (I_SRST)
      I_CE && ((bfn == FN_OFF) || (bfn >= FN_PWRDN)) |=> !O_BIDIR_OE;
  endproperty
  a_input_hiz: assert property (p_input_hiz) else $error("input pin driven");

  property p_mclk;
    @(posedge I_REF_CLK) disable iff (I_SRST)
      I_CE && (bfn == FN_MCLK) |=> (O_MCLK == $past(q.bsync[1])) && !O_SER_IN;
  endproperty
  a_mclk: assert property (p_mclk) else $error("master clock not routed");

  property p_pdma;
    @(posedge I_REF_CLK) disable iff (I_SRST)
      I_CE && (bfn == FN_PDMA) |=> (O_PDM_DIN_A == $past(q.bsync[1])) && !O_PDM_DIN_B;
  endproperty
  a_pdma: assert property (p_pdma) else $error("first pulse-density input not routed");

  property p_route_off;
    @(posedge I_REF_CLK) disable iff (I_SRST)
      I_CE && (bfn < FN_PWRDN) |=> (q.route == '0);
  endproperty
  a_route_off: assert property (p_route_off) else $error("input route active");

  property p_pulse_density_clock_out_out;
    @(posedge I_REF_CLK) disable iff (I_SRST)
      I_CE && (bfn == FN_PDMCK) && (bdrv == DRV_PP) |=>
        O_BIDIR_OE && (O_BIDIR_OUT == $past(I_PDM_CLK));
  endproperty
  a_pulse_density_clock_out_out: assert property (p_pulse_density_clock_out_out) else $error("clock not on bidir pin");

  property p_weak_high;
    @(posedge I_REF_CLK) disable iff (I_SRST)
      I_CE && (bfn == FN_GEN_OUT) && (bdrv == DRV_SLWH) |=>
        O_BIDIR_OE && (O_BIDIR_WEAK == O_BIDIR_OUT);
  endproperty
  a_weak_high: assert property (p_weak_high) else $error("weak high drive wrong");

  property p_weak_low;
    @(posedge I_REF_CLK) disable iff (I_SRST)
      I_CE && (bfn == FN_GEN_OUT) && (bdrv == DRV_WLSH) |=>
        O_BIDIR_OE && (O_BIDIR_WEAK != O_BIDIR_OUT);
  endproperty
  a_weak_low: assert property (p_weak_low) else $error("weak low drive wrong");

  property p_hiz_drv;
    @(posedge I_REF_CLK) disable iff (I_SRST)
      I_CE && (bdrv == DRV_HIZ) |=> !O_BIDIR_OE;
  endproperty
  a_hiz_drv: assert property (p_hiz_drv) else $error("high impedance drive enabled");

  property p_out_off;
    @(posedge I_REF_CLK) disable iff (I_SRST)
      I_CE && (ofn == FN_OFF) |=> !O_OUT_OE;
  endproperty
  a_out_off: assert property (p_out_off) else $error("disabled output pin driven");

  property p_out_zlsh;
    @(posedge I_REF_CLK) disable iff (I_SRST)
      I_CE && (ofn == FN_GEN_OUT) && (odrv == DRV_ZLSH) && !q.oval |=> !O_OUT_OE;
  endproperty
  a_out_zlsh: assert property (p_out_zlsh) else $error("released low still driven");

  property p_out_rsv_fn;
    @(posedge I_REF_CLK) disable iff (I_SRST)
      I_CE && (ofn > FN_PDMCK) |=> !O_OUT_OE;
  endproperty
  a_out_rsv_fn: assert property (p_out_rsv_fn) else $error("reserved function driven");

  property p_cfg_rsv;
    @(posedge I_REF_CLK) disable iff (I_SRST)
      !q.bcfg[MPC_RSV_BIT] && !q.ocfg[MPC_RSV_BIT];
  endproperty
  a_cfg_rsv: assert property (p_cfg_rsv) else $error("reserved config bit set");

  c_write: cover property (@(posedge I_REF_CLK) q.rsp.bvalid && I_AXI.bready);
  c_read: cover property (@(posedge I_REF_CLK) q.rsp.rvalid && I_AXI.rready);
  c_weak: cover property (@(posedge I_REF_CLK) O_BIDIR_OE && O_BIDIR_WEAK);
  c_pulse_density_clock_out: cover property (@(posedge I_REF_CLK) (ofn == FN_PDMCK) && O_OUT_OE);
  c_gen_in: cover property (@(posedge I_REF_CLK) (bfn == FN_GEN_IN) && O_GEN_IN);

endmodule : mpc_top

/* mpc_peer.sv */
`timescale 1ns/1ps
module mpc_peer (
  input  wire logic clk,
  input  wire logic i_oe,
  input  wire logic i_out,
  output logic      o_pad,
  output logic      o_irq,
  output logic      o_pdm_clk
);
  logic [3:0] cnt_q = 4'h0;

  always @(posedge clk) begin
    cnt_q <= cnt_q + 4'h1;
  end

  assign o_pdm_clk = cnt_q[0];
  assign o_irq     = cnt_q[3] ^ cnt_q[1];
  // Released pad shows a moving pattern, never a held value
  assign o_pad     = i_oe ? i_out : (cnt_q[0] ^ cnt_q[2]);
endmodule : mpc_peer

/* testbench.sv */
`timescale 1ns/1ps
module testbench;
  import mpc_pkg::*;
  logic         clk  = 1'b0;
  logic         srst = 1'b1;
  logic         ce   = 1'b1;
  logic [11:0]  snap;
  mpc_axi_req_t req  = '0;
  mpc_axi_rsp_t rsp;
  logic         pad, irq, pck, bo, boe, bwk, oo, ooe;
  logic [6:0]   rt;
  logic         irq_s, pck_s;
  logic [2:0]   pipe;
  logic [31:0]  rnd = 32'h1d08;
  logic [7:0]   bc, oc, v;
  int           err_total = 0;
  int           checked = 0;
  int           cyc = 0;
  logic [3:0]   bf [11] = '{FN_OFF, FN_GEN_OUT, FN_IRQ, FN_PDMCK, FN_PWRDN, FN_BIAS, FN_GEN_IN,
                            FN_MCLK, FN_SER_IN, FN_PDMA, FN_PDMB};
  logic [3:0]   of [4] = '{FN_OFF, FN_GEN_OUT, FN_IRQ, FN_PDMCK};
  logic [2:0]   od [8] = '{DRV_HIZ, DRV_PP, DRV_SLWH, DRV_SLZH, DRV_WLSH, DRV_ZLSH,
                           3'h6, 3'h7};

  always #2.5 clk = ~clk;

  mpc_peer u_peer (.clk(clk), .i_oe(boe), .i_out(bo), .o_pad(pad), .o_irq(irq), .o_pdm_clk(pck));

  mpc_top u_dut (.I_REF_CLK(clk), .I_SRST(srst), .I_CE(ce), .I_AXI(req), .O_AXI(rsp),
    .I_BIDIR_IN(pad), .I_IRQ(irq), .I_PDM_CLK(pck), .O_BIDIR_OUT(bo), .O_BIDIR_OE(boe),
    .O_BIDIR_WEAK(bwk), .O_OUT_OUT(oo), .O_OUT_OE(ooe), .O_ADC_PWRDN(rt[6]), .O_BIAS_EN(rt[5]),
    .O_GEN_IN(rt[4]), .O_MCLK(rt[3]), .O_SER_IN(rt[2]), .O_PDM_DIN_A(rt[1]),
    .O_PDM_DIN_B(rt[0]));

  task automatic print_verdict();
    if (err_total == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  always @(posedge clk) begin
    irq_s <= irq;
    pck_s <= pck;
    pipe  <= {pipe[1:0], pad};
    cyc   <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      print_verdict();
    end
  end

  task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : cmp

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] st,
                    input logic [1:0] er);
    int n;
    n = 0;
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= {rnd[23:0], d};
    req.wstrb   <= st;
    req.bready  <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1 && n < 50);
    req.bready <= 1'b0;
    cmp(rsp.bvalid, 1'b1);
    cmp(rsp.bresp, er);
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1 && n < 50);
    req.rready <= 1'b0;
    cmp(rsp.rdata, ed);
    cmp(rsp.rresp, er);
    @(posedge clk);
  endtask : rd

  // Expected {oe, out, weak} of a pin for its config and value bit
  function automatic logic [2:0] drv(input logic [7:0] c, input logic gv, input logic op);
    logic s;
    logic en;
    en = 1'b1;
    case (c[7:4])
      FN_GEN_OUT: s = gv;
      FN_IRQ:   s = irq_s;
      FN_PDMCK: s = pck_s;
      default: begin
        s  = 1'b0;
        en = 1'b0;
      end
    endcase
    case (c[2:0])
      DRV_PP:   return {en, s, 1'b0};
      DRV_SLWH: return op ? 3'h0 : {en, s, s};
      DRV_SLZH: return {en & ~s, 1'b0, 1'b0};
      DRV_WLSH: return op ? 3'h0 : {en, s, ~s};
      DRV_ZLSH: return {en & s, s, 1'b0};
      default:  return 3'h0;
    endcase
  endfunction : drv

  task automatic pins(input logic [7:0] c, input logic [7:0] k, input logic [7:0] gv);
    logic [2:0] e;
    logic [2:0] o;
    logic [6:0] r;
    repeat (3) @(posedge clk);
    repeat (6) begin
      @(posedge clk);
      #1;
      e = drv(c, gv[MPC_BVAL_BIT], 1'b0);
      o = drv(k, gv[MPC_OVAL_BIT], 1'b1);
      r = 7'h0;
      if (c[7:4] >= FN_PWRDN && c[7:4] <= FN_PDMB) r[4'd13 - c[7:4]] = pipe[2];
      cmp(boe, e[2]);
      if (e[2]) cmp({bo, bwk}, e[1:0]);
      cmp(ooe, o[2]);
      if (o[2]) cmp(oo, o[1]);
      cmp(rt, r);
    end
  endtask : pins

  initial begin
    repeat (20) @(posedge clk);
    cmp({rsp.awready, rsp.wready, rsp.arready}, 3'h0);
    srst <= 1'b0;
    @(posedge clk);
    rd(MPC_ADDR_BCFG, 32'h22, MPC_RESP_OKAY);
    rd(MPC_ADDR_OCFG, 32'h0, MPC_RESP_OKAY);
    rd(MPC_ADDR_VAL, 32'h0, MPC_RESP_OKAY);
    pins(MPC_BCFG_RST, MPC_OCFG_RST, 8'h0);
    wr(MPC_ADDR_BCFG, 8'h9d, 4'hf, MPC_RESP_OKAY);
    rd(MPC_ADDR_BCFG, 32'h95, MPC_RESP_OKAY);
    wr(MPC_ADDR_OCFG, 8'h1d, 4'hf, MPC_RESP_OKAY);
    rd(MPC_ADDR_OCFG, 32'h15, MPC_RESP_OKAY);
    wr(MPC_ADDR_BCFG, 8'h40, 4'he, MPC_RESP_OKAY);
    rd(MPC_ADDR_BCFG, 32'h95, MPC_RESP_OKAY);
    wr(8'h8c, 8'h11, 4'hf, MPC_RESP_SLVERR);
    rd(8'h8c, 32'h0, MPC_RESP_SLVERR);
    rd(8'h85, 32'h0, MPC_RESP_SLVERR);
    foreach (bf[i]) begin
      for (int d = 0; d < 6; d++) begin
        rnd = xs(rnd);
        bc  = {bf[i], 1'b0, 3'(d)};
        oc  = {of[rnd[1:0]], 1'b0, od[rnd[4:2]]};
        v   = {rnd[9:8], 6'h0};
        wr(MPC_ADDR_BCFG, bc, 4'hf, MPC_RESP_OKAY);
        wr(MPC_ADDR_OCFG, oc, 4'hf, MPC_RESP_OKAY);
        wr(MPC_ADDR_VAL, v, 4'hf, MPC_RESP_OKAY);
        rd(MPC_ADDR_BCFG, {24'h0, bc}, MPC_RESP_OKAY);
        rd(MPC_ADDR_OCFG, {24'h0, oc}, MPC_RESP_OKAY);
        rd(MPC_ADDR_VAL, {24'h0, v}, MPC_RESP_OKAY);
        if (bf[i] != FN_GEN_IN) rd(MPC_ADDR_MON, 32'h0, MPC_RESP_OKAY);
        pins(bc, oc, v);
      end
    end
    // Clock enable low must freeze a toggling clock output
    bc = {FN_PDMCK, 1'b0, DRV_PP};
    wr(MPC_ADDR_BCFG, bc, 4'hf, MPC_RESP_OKAY);
    repeat (3) @(posedge clk);
    ce <= 1'b0;
    @(posedge clk);
    #1;
    snap = {boe, bo, bwk, ooe, oo, rt};
    repeat (4) @(posedge clk);
    #1;
    cmp({boe, bo, bwk, ooe, oo, rt}, snap);
    @(posedge clk);
    ce <= 1'b1;
    pins(bc, oc, v);
    print_verdict();
  end
endmodule : testbench
